// ---- design/p56io_pkg.sv ----
// Purpose: Shared constants and carrier types for the port 5 / port 6 pin control block
// Assumes: Register index map is local to this block; one 8-bit register per index
// Notes:   Segment-group select comes from the LCD port control logic outside
package p56io_pkg;

  localparam int unsigned PORT_W    = 8;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned SGS_W     = 4;

  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_P5_DATA   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_P5_DIR    = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_P5_PULLUP = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_P5_MODE   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_P6_DATA   = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_P6_DIR    = 3'h5;

  // Reset values and fixed read values
  localparam logic [PORT_W-1:0] RST_BYTE     = 8'h00;
  localparam logic [PORT_W-1:0] WO_READ_BYTE = 8'hff;
  localparam logic [PORT_W-1:0] UNMAPPED_RD  = 8'h00;

  // Segment-group select windows
  localparam logic [SGS_W-1:0] P5_HI_SEG_LO = 4'h2;
  localparam logic [SGS_W-1:0] P5_HI_SEG_HI = 4'h9;
  localparam logic [SGS_W-1:0] P5_LO_SEG_LO = 4'h1;
  localparam logic [SGS_W-1:0] P5_LO_SEG_HI = 4'h8;
  localparam logic [SGS_W-1:0] P6_HI_SEG_LO = 4'h4;
  localparam logic [SGS_W-1:0] P6_HI_SEG_HI = 4'hb;
  localparam logic [SGS_W-1:0] P6_LO_SEG_LO = 4'h3;
  localparam logic [SGS_W-1:0] P6_LO_SEG_HI = 4'ha;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } p56io_bus_req_t;

  // Per-port pin drive bundle
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] seg_sel;
  } p56io_pin_drv_t;

  // All register state
  typedef struct packed {
    logic [PORT_W-1:0] p5_data;
    logic [PORT_W-1:0] p5_dir;
    logic [PORT_W-1:0] p5_pullup;
    logic [PORT_W-1:0] p5_mode;
    logic [PORT_W-1:0] p6_data;
    logic [PORT_W-1:0] p6_dir;
    logic [PORT_W-1:0] rdata;
  } p56io_state_t;

  // True when the select field lies in an inclusive window
  function automatic logic p56io_in_window(input logic [SGS_W-1:0] sgs,
                                           input logic [SGS_W-1:0] lo,
                                           input logic [SGS_W-1:0] hi);
    return (sgs >= lo) && (sgs <= hi);
  endfunction

endpackage

// ---- design/p56io_pin_mux.sv ----
// Purpose: Combinational pin function select for one 8-bit port
// Assumes: Segment decision per nibble is made by the caller
// Notes:   Mode bits may be tied low for ports without a wakeup function
`timescale 1ns/100ps
module p56io_pin_mux
  import p56io_pkg::*;
(
  // Nibble segment assignment
  input  wire logic              seg_hi,
  input  wire logic              seg_lo,
  // Register values
  input  wire logic [PORT_W-1:0] dir,
  input  wire logic [PORT_W-1:0] data,
  input  wire logic [PORT_W-1:0] mode,
  input  wire logic [PORT_W-1:0] pullup_en,
  // Resulting pin controls
  output p56io_pin_drv_t         drv,
  output logic [PORT_W-1:0]      pullup_on,
  output logic [PORT_W-1:0]      wake_en
);

  logic [PORT_W-1:0] seg_mask;
  logic [PORT_W-1:0] gpio_mask;

  // Segment overrides mode and direction; no registers here so changes act at once
  assign seg_mask  = {{4{seg_hi}}, {4{seg_lo}}};    // see [R5] see [R6] see [R12] see [R16]
  assign gpio_mask = ~seg_mask & ~mode;             // see [R15]
  assign wake_en   = ~seg_mask & mode;              // see [R4] see [R7]
  assign drv.seg_sel = seg_mask;
  assign drv.oe      = gpio_mask & dir;             // see [R7] see [R10]
  assign drv.out     = gpio_mask & dir & data;
  // Pull-up only on a general input; off for outputs, wakeup and segment pins
  assign pullup_on   = gpio_mask & ~dir & pullup_en;   // see [R1]

endmodule // p56io_pin_mux

// ---- design/p56io_port_ctrl.sv ----
// Purpose: Register file and pin muxing for two 8-bit ports shared with LCD segments and wakeup inputs
// Assumes: Pins and bus inputs are synchronous to clk; segment select arrives from LCD control
// Notes:   Pull-up on a wakeup pin is left off, as only general inputs get it
//
// Contract
// [R1] Port 5 pull-up is on only when direction is 0 and pull-up bit is 1.
// [R2] All port 5 pull-ups are off after reset.
// [R3] Port 5 pull-up register holds eight read/write bits, reset to zero.
// [R4] Port 5 mode bit picks general I/O at 0, wakeup input at 1.
// [R5] Port 5 pins 7..4 are segment outputs for select values 2 through 9.
// [R6] Port 5 pins 3..0 are segment outputs for select values 1 through 8.
// [R7] Non-segment port 5 pin: wakeup if mode 1, else direction picks input/output.
// [R8] Port 6 data read gives latch for outputs, live pin for inputs.
// [R9] Port 6 data register holds eight read/write latch bits, reset to zero.
// [R10] Port 6 direction bit 1 makes output, 0 input; resets to zero.
// [R11] Port 6 direction register is write-only and reads as all ones.
// [R12] Port 6 settings act only while the pin is not a segment output.
// [R13] Port 5 data read gives latch for outputs, live pin for inputs.
// [R14] Port 5 direction register is write-only, reads all ones; 1 means output.
// [R15] Port 5 settings act only when mode and select both give general I/O.
// [R16] Writes take effect next cycle; pin mux is purely combinational.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module p56io_port_ctrl
  import p56io_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [PORT_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [PORT_W-1:0]      rdata,
  // LCD segment interface
  input  wire logic [SGS_W-1:0]  segment_group_select,
  input  wire logic [PORT_W-1:0] p5_lcd_segment_output,
  input  wire logic [PORT_W-1:0] p6_lcd_segment_output,
  // Port 5 pins
  input  wire logic [PORT_W-1:0] port5_general_pin_in,
  output logic [PORT_W-1:0]      port5_general_pin_out,
  output logic [PORT_W-1:0]      port5_general_pin_oe,
  output logic [PORT_W-1:0]      port5_pullup_on,
  output logic [PORT_W-1:0]      port5_wake_enable,
  // Port 6 pins
  input  wire logic [PORT_W-1:0] port6_general_pin_in,
  output logic [PORT_W-1:0]      port6_general_pin_out,
  output logic [PORT_W-1:0]      port6_general_pin_oe
);

  p56io_bus_req_t    req;
  p56io_state_t      st_reg;
  p56io_state_t      st_next;
  p56io_pin_drv_t    p5_drv;
  p56io_pin_drv_t    p6_drv;
  logic              p5_seg_hi;
  logic              p5_seg_lo;
  logic              p6_seg_hi;
  logic              p6_seg_lo;
  logic [PORT_W-1:0] p6_wake_unused;
  logic [PORT_W-1:0] p6_pull_unused;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Segment windows per nibble
  assign p5_seg_hi = p56io_in_window(segment_group_select, P5_HI_SEG_LO, P5_HI_SEG_HI); // see [R5]
  assign p5_seg_lo = p56io_in_window(segment_group_select, P5_LO_SEG_LO, P5_LO_SEG_HI); // see [R6]
  assign p6_seg_hi = p56io_in_window(segment_group_select, P6_HI_SEG_LO, P6_HI_SEG_HI); // see [R12]
  assign p6_seg_lo = p56io_in_window(segment_group_select, P6_LO_SEG_LO, P6_LO_SEG_HI); // see [R12]

  // Next-state: register writes and registered read data
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = RST_BYTE;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_P5_DATA:   st_next.p5_data   = req.wdata;
        ADDR_P5_DIR:    st_next.p5_dir    = req.wdata;   // see [R14]
        ADDR_P5_PULLUP: st_next.p5_pullup = req.wdata;   // see [R3]
        ADDR_P5_MODE:   st_next.p5_mode   = req.wdata;   // see [R4]
        ADDR_P6_DATA:   st_next.p6_data   = req.wdata;   // see [R9]
        ADDR_P6_DIR:    st_next.p6_dir    = req.wdata;   // see [R10]
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        // Input pins read live level, outputs read the latch
        ADDR_P5_DATA:   st_next.rdata = (st_reg.p5_dir & st_reg.p5_data)
                                      | (~st_reg.p5_dir & port5_general_pin_in);  // see [R13]
        ADDR_P5_DIR:    st_next.rdata = WO_READ_BYTE;                              // see [R14]
        ADDR_P5_PULLUP: st_next.rdata = st_reg.p5_pullup;                          // see [R3]
        ADDR_P5_MODE:   st_next.rdata = st_reg.p5_mode;
        ADDR_P6_DATA:   st_next.rdata = (st_reg.p6_dir & st_reg.p6_data)
                                      | (~st_reg.p6_dir & port6_general_pin_in);  // see [R8]
        ADDR_P6_DIR:    st_next.rdata = WO_READ_BYTE;                              // see [R11]
        default:        st_next.rdata = UNMAPPED_RD;
      endcase
    end
  end

  // State register; everything clears so pull-ups start off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;   // see [R2] see [R9] see [R10]
    end else begin
      st_reg <= st_next;   // see [R16]
    end
  end

  assign rdata = st_reg.rdata;

  // Port 5: mode register steers wakeup function
  p56io_pin_mux u_p5_mux (
    .seg_hi    (p5_seg_hi),
    .seg_lo    (p5_seg_lo),
    .dir       (st_reg.p5_dir),
    .data      (st_reg.p5_data),
    .mode      (st_reg.p5_mode),
    .pullup_en (st_reg.p5_pullup),
    .drv       (p5_drv),
    .pullup_on (port5_pullup_on),
    .wake_en   (port5_wake_enable)
  );

  // Port 6: no wakeup, pull-up handled elsewhere
  p56io_pin_mux u_p6_mux (
    .seg_hi    (p6_seg_hi),
    .seg_lo    (p6_seg_lo),
    .dir       (st_reg.p6_dir),
    .data      (st_reg.p6_data),
    .mode      (RST_BYTE),
    .pullup_en (RST_BYTE),
    .drv       (p6_drv),
    .pullup_on (p6_pull_unused),
    .wake_en   (p6_wake_unused)
  );

  // Segment pins are always driven by the LCD data
  assign port5_general_pin_out = (p5_drv.seg_sel & p5_lcd_segment_output) | p5_drv.out;  // see [R5] see [R6]
  assign port5_general_pin_oe  = p5_drv.seg_sel | p5_drv.oe;                              // see [R15]
  assign port6_general_pin_out = (p6_drv.seg_sel & p6_lcd_segment_output) | p6_drv.out;  // see [R12]
  assign port6_general_pin_oe  = p6_drv.seg_sel | p6_drv.oe;                              // see [R12]

  // Checks
  a_p5_pullup_gate: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
    (st_reg.p5_dir[0] || st_reg.p5_mode[0] || p5_seg_lo) |-> !port5_pullup_on[0])
    else $error("pull-up on while pin not general input");
  a_p5_pullup_on: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
    (!st_reg.p5_dir[7] && !st_reg.p5_mode[7] && !p5_seg_hi && st_reg.p5_pullup[7]) |-> port5_pullup_on[7])
    else $error("pull-up missing on general input");
  a_reset_pullup: assert property (@(posedge clk) // see [R2]
    $rose(rst_n) |-> port5_pullup_on == RST_BYTE)
    else $error("pull-up on after reset");
  a_pullup_write: assert property (@(posedge clk) disable iff (!rst_n) // see [R3]
    (wr && addr == ADDR_P5_PULLUP) ##1 (rd && addr == ADDR_P5_PULLUP) |=> rdata == $past(wdata, 2))
    else $error("pull-up register readback wrong");
  a_p5_hi_segment: assert property (@(posedge clk) disable iff (!rst_n) // see [R5]
    (segment_group_select == 4'h9) |-> (port5_general_pin_oe[7:4] == 4'hf && port5_wake_enable[7:4] == 4'h0))
    else $error("port 5 high nibble not segment");
  a_p5_lo_segment: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
    (segment_group_select == 4'h9) |-> p5_drv.seg_sel[3:0] == 4'h0)
    else $error("port 5 low nibble wrongly segment");
  a_p5_wake_sel: assert property (@(posedge clk) disable iff (!rst_n) // see [R7]
    (st_reg.p5_mode[2] && !p5_seg_lo) |-> (port5_wake_enable[2] && !port5_general_pin_oe[2]))
    else $error("wakeup pin not an input");
  a_p6_data_read: assert property (@(posedge clk) disable iff (!rst_n) // see [R8]
    (rd && addr == ADDR_P6_DATA) |=>
      rdata == (($past(st_reg.p6_dir) & $past(st_reg.p6_data)) | (~$past(st_reg.p6_dir) & $past(port6_general_pin_in))))
    else $error("port 6 data read mixes wrong sources");
  a_dir_read_ones: assert property (@(posedge clk) disable iff (!rst_n) // see [R11]
    (rd && (addr == ADDR_P6_DIR || addr == ADDR_P5_DIR)) |=> rdata == WO_READ_BYTE)
    else $error("direction read not all ones");
  a_p6_dir_out: assert property (@(posedge clk) disable iff (!rst_n) // see [R10]
    (wr && addr == ADDR_P6_DIR && wdata[0] && segment_group_select == 4'h0) |=> port6_general_pin_oe[0])
    else $error("port 6 direction write not applied next cycle");

endmodule // p56io_port_ctrl

// ---- testbench/p56io_pin_partner.sv ----
// Purpose: Pin-side model: block drive, pull-ups and an outside source
// Assumes: Outside source drives only where its enable bit is set
// Notes:   Floating pins show the inverted source value so a stale level never passes
`timescale 1ns/100ps
module p56io_pin_partner
  import p56io_pkg::*;
(
  // Block drive
  input  wire logic [PORT_W-1:0] p5_out,
  input  wire logic [PORT_W-1:0] p5_oe,
  input  wire logic [PORT_W-1:0] p5_pu,
  input  wire logic [PORT_W-1:0] p6_out,
  input  wire logic [PORT_W-1:0] p6_oe,
  // Outside source
  input  wire logic [PORT_W-1:0] ext,
  input  wire logic [PORT_W-1:0] ext_en,
  // Resolved pin levels
  output logic [PORT_W-1:0]      p5_lvl,
  output logic [PORT_W-1:0]      p6_lvl
);
  // Block drive wins; pull-up only lifts an undriven pin
  assign p5_lvl = (p5_oe & p5_out) | (~p5_oe & ext_en & ext) | (~p5_oe & ~ext_en & (p5_pu | ~ext));
  assign p6_lvl = (p6_oe & p6_out) | (~p6_oe & ext_en & ext) | (~p6_oe & ~ext_en & ~ext);
endmodule // p56io_pin_partner

// ---- testbench/testbench.sv ----
// Purpose: Random register and pin traffic checked against a bench model
// Assumes: Index map and read values as set in the package
// Notes:   Every random operation is a write followed at once by a read; the reset sweep only reads
`timescale 1ns/100ps
module testbench
  import p56io_pkg::*;
;
  // Stimulus and observed signals
  logic             clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0]       addr = 3'h0;
  logic [3:0]       sgs = 4'h0;
  logic [7:0]       wdata = 8'h00, seg5 = 8'h00, seg6 = 8'h00, ext = 8'h00, ext_en = 8'h00;
  logic [7:0]       rdata, p5o, p5e, p5p, p5w, p6o, p6e, p5l, p6l, k5, k6, g5, exp_rd;
  logic [7:0]       m [0:5] = '{default: 8'h00};
  int               n_errors = 0, cmp_count = 0, i;
  int               seed = 32'h01b1;

  always #10 clk = ~clk;

  p56io_port_ctrl u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .segment_group_select(sgs), .p5_lcd_segment_output(seg5), .p6_lcd_segment_output(seg6),
    .port5_general_pin_in(p5l), .port5_general_pin_out(p5o), .port5_general_pin_oe(p5e),
    .port5_pullup_on(p5p), .port5_wake_enable(p5w), .port6_general_pin_in(p6l),
    .port6_general_pin_out(p6o), .port6_general_pin_oe(p6e));

  p56io_pin_partner u_pins (.p5_out(p5o), .p5_oe(p5e), .p5_pu(p5p), .p6_out(p6o), .p6_oe(p6e),
    .ext(ext), .ext_en(ext_en), .p5_lvl(p5l), .p6_lvl(p6l));

  // Segment ownership per nibble and general-I/O mask of port 5
  always_comb begin
    k5 = {{4{sgs >= 4'h2 && sgs <= 4'h9}}, {4{sgs >= 4'h1 && sgs <= 4'h8}}};
    k6 = {{4{sgs >= 4'h4 && sgs <= 4'hb}}, {4{sgs >= 4'h3 && sgs <= 4'ha}}};
    g5 = ~k5 & ~m[3];
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Pin outputs from the model registers
  task automatic check_pins;
    chk(p5e, k5 | (g5 & m[1]));
    chk(p5o, (k5 & seg5) | (g5 & m[1] & m[0]));
    chk(p5p, g5 & ~m[1] & m[2]);
    chk(p5w, ~k5 & m[3]);
    chk(p6e, k6 | (~k6 & m[5]));
    chk(p6o, (k6 & seg6) | (~k6 & m[5] & m[4]));
  endtask

  // Read value the model predicts, live pins taken from the pin model
  function automatic logic [7:0] rd_model(input logic [2:0] a);
    case (a)
      3'h0: return (m[1] & m[0]) | (~m[1] & p5l);
      3'h1, 3'h5: return 8'hff;
      3'h2, 3'h3: return m[a];
      3'h4: return (m[5] & m[4]) | (~m[5] & p6l);
      default: return 8'h00;
    endcase
  endfunction

  // One write cycle, then a read in the very next cycle
  task automatic op(input logic w, input logic [2:0] wa, input logic [7:0] wd, input logic [2:0] ra);
    @(posedge clk);
    wr <= w;
    addr <= wa;
    wdata <= wd;
    sgs <= 4'($random(seed));
    seg5 <= 8'($random(seed));
    seg6 <= 8'($random(seed));
    ext <= 8'($random(seed));
    ext_en <= 8'($random(seed));
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= ra;
    if (w && wa < 3'h6) m[wa] = wd;
    @(negedge clk);
    check_pins;
    chk(rdata, 8'h00);
    exp_rd = rd_model(ra);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp_rd);
  endtask

  // Reset, reset-value sweep, then random traffic incl. unmapped indices
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) op(1'b0, 3'h0, 8'h00, 3'(i));
    repeat (400) op(1'b1, 3'($random(seed)), 8'($random(seed)), 3'($random(seed)));
    test_done;
  end

  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
endmodule // testbench
